// >>> verilog/fcc_pkg.sv
// Shared constants, command codes and carrier types of the flash command controller.
package fcc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] FCC_ADDR_STATUS = 32'hffff0e00;
    localparam logic [31:0] FCC_ADDR_MODE = 32'hffff0e04;
    localparam logic [31:0] FCC_ADDR_CMD = 32'hffff0e08;
    localparam logic [31:0] FCC_ADDR_DATA = 32'hffff0e0c;
    localparam logic [31:0] FCC_ADDR_WADDR = 32'hffff0e10;
    localparam logic [31:0] FCC_ADDR_SIGN = 32'hffff0e18;
    localparam logic [31:0] FCC_ADDR_PROT = 32'hffff0e1c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int FCC_ST_PASS = 0;
    localparam int FCC_ST_FAIL = 1;
    localparam int FCC_ST_BUSY = 2;
    localparam int FCC_ST_IRQ = 3;
    localparam logic [15:0] FCC_STATUS_RESET = 16'h0020;
    localparam int FCC_MODE_WREN = 3;
    localparam int FCC_MODE_IRQEN = 4;
    localparam logic [15:0] FCC_MODE_RESET = 16'h0000;
    localparam logic [7:0] FCC_CMD_RESET = 8'h07;
    localparam logic [7:0] FCC_CMD_DONE = 8'h07;
    localparam logic [15:0] FCC_DATA_RESET = 16'h0000;
    localparam logic [15:0] FCC_WADDR_RESET = 16'h0000;
    localparam logic [23:0] FCC_SIGN_RESET = 24'hffffff;
    localparam logic [23:0] FCC_SIGN_TAPS = 24'he10000;
    localparam logic [31:0] FCC_PROT_RESET = 32'h00000000;
    // Unlock value for saved protection; the value is arbitrary.
    localparam logic [31:0] FCC_PROT_KEY = 32'h5a5aa5a5;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] FCC_OP_NULL = 8'h00;
    localparam logic [7:0] FCC_OP_READ = 8'h01;
    localparam logic [7:0] FCC_OP_WRITE = 8'h02;
    localparam logic [7:0] FCC_OP_ERASE_WRITE = 8'h03;
    localparam logic [7:0] FCC_OP_VERIFY = 8'h04;
    localparam logic [7:0] FCC_OP_PAGE_ERASE = 8'h05;
    localparam logic [7:0] FCC_OP_MASS_ERASE = 8'h06;
    localparam logic [7:0] FCC_OP_SIGN = 8'h0b;
    localparam logic [7:0] FCC_OP_PROTECT = 8'h0c;
    localparam logic [7:0] FCC_OP_PING = 8'h0f;

    // ------------------------------------------------------------------
    // Mass erase key and array geometry
    // ------------------------------------------------------------------
    localparam logic [15:0] FCC_KEY_DATA = 16'h3cff;
    localparam logic [15:0] FCC_KEY_ADDR = 16'h77c3;
    localparam logic [15:0] FCC_USER_ADDR_MAX = 16'h77ff;
    localparam int FCC_MEM_AW = 14;
    localparam int FCC_MEM_DW = 16;
    localparam logic [13:0] FCC_USER_LAST = 14'h3bff;
    localparam logic [7:0] FCC_PAGE_LAST = 8'hff;
    localparam logic [15:0] FCC_ERASED = 16'hffff;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int FCC_CLK_MHZ = 20;
    localparam int FCC_TMR_W = 20;
    localparam int FCC_WRITE_TIME_US = 50;
    localparam logic [19:0] FCC_WRITE_CYCLES = 20'(FCC_WRITE_TIME_US * FCC_CLK_MHZ);
    localparam int FCC_ERASE_WRITE_TIME_MS = 24;
    localparam int FCC_ERASE_WRITE_CYCLES = FCC_ERASE_WRITE_TIME_MS * 1000 * FCC_CLK_MHZ;
    localparam int FCC_PAGE_ERASE_TIME_MS = 20;
    localparam int FCC_PAGE_ERASE_CYCLES = FCC_PAGE_ERASE_TIME_MS * 1000 * FCC_CLK_MHZ;
    localparam int FCC_MASS_ERASE_TIME_MS = 24;
    localparam int FCC_MASS_ERASE_CYCLES = FCC_MASS_ERASE_TIME_MS * 1000 * FCC_CLK_MHZ;
    localparam int FCC_SIGN_CYCLES = 16389;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FCC_IDLE,
        FCC_READ,
        FCC_CAP,
        FCC_ERASE,
        FCC_PROG,
        FCC_SIGN,
        FCC_WAIT
    } fcc_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fcc_bus_req_s;

    typedef struct packed {
        logic we;
        logic [13:0] addr;
        logic [15:0] wdata;
    } fcc_mem_req_s;

endpackage

// >>> verilog/fcc_array.sv
// Word-wide storage array of the flash with a registered read port.
`timescale 1ns/10ps

module fcc_array (
    // Clock.
    input wire logic i_mclk,
    // Access port.
    input wire fcc_pkg::fcc_mem_req_s i_req,
    output logic [15:0] o_rdata
);
    import fcc_pkg::*;

    logic [FCC_MEM_DW-1:0] mem_ff [0:(1<<FCC_MEM_AW)-1];

    // Read data always come out of a register, one cycle after the address.
    always_ff @(posedge i_mclk) begin
        if (i_req.we) begin
            mem_ff[i_req.addr] <= i_req.wdata;
        end
        o_rdata <= mem_ff[i_req.addr];
    end

endmodule

// >>> verilog/fcc_ctrl.sv
// Command sequencer and register file of the flash command controller.
`timescale 1ns/10ps

//
// Behaviour
// (R01) Status interrupt bit sets on completion with interrupt enabled; clears on status read.
// (R02) Status busy bit is high exactly while an operation runs.
// (R03) Status fail bit sets on unsuccessful completion; clears on status read.
// (R04) Status pass bit sets on successful completion; clears on status read.
// (R05) Mode bit 4 gates the completion interrupt.
// (R06) Erase and write commands run only while mode bit 3 is set.
// (R07) Software writes mode bit 8 one, bits 7:5 and 2:0 zero.
// (R08) Command register is eight bits, resets to 0x07; writing a code starts it.
// (R09) Code 0x01 loads the data register from the addressed word.
// (R10) Code 0x02 programs the data register value, taking 50 us.
// (R11) Erase/write erases the page then writes the word, taking 24 ms.
// (R12) Verify compares the addressed word; match sets pass, mismatch sets fail.
// (R13) Code 0x05 erases the 512 byte page holding the address.
// (R14) Code 0x06 erases the 30 kB user region only, after the key.
// (R15) Code 0x0B loads a 24-bit LFSR signature, taking 16389 cycles.
// (R16) Code 0x0C saves protection once; mass erase or key removes it.
// (R17) Code 0x0F touches nothing but still completes and interrupts; the code raises the interrupt only while mode bit 4 is set.
// (R18) Mass erase needs data 0x3CFF, address 0x77C3, mode 0x8, then command.
// (R19) After codes 0x00 to 0x06 the command register reads 0x07.
// (R20) Addresses above 0x77FF raise a data abort instead of an access.
// (R21) Reserved codes leave array and status flags untouched.
module fcc_ctrl #(
    parameter int P_ERASE_WRITE_CYCLES = fcc_pkg::FCC_ERASE_WRITE_CYCLES,
    parameter int P_PAGE_ERASE_CYCLES = fcc_pkg::FCC_PAGE_ERASE_CYCLES,
    parameter int P_MASS_ERASE_CYCLES = fcc_pkg::FCC_MASS_ERASE_CYCLES,
    parameter int P_SIGN_CYCLES = fcc_pkg::FCC_SIGN_CYCLES
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Register bus.
    input wire fcc_pkg::fcc_bus_req_s i_bus,
    output logic [31:0] o_bus_rdata,
    output logic o_data_abort,
    // System side.
    output logic o_flash_irq,
    output logic o_busy,
    output logic [31:0] o_protection,
    output logic o_protection_locked
);
    import fcc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fcc_state_e state_ff, nxt_state;
    logic [15:0] mode_ff;
    logic [7:0] cmd_ff;
    logic [7:0] op_ff;
    logic [15:0] data_ff;
    logic [15:0] waddr_ff;
    logic [23:0] sign_ff;
    logic [23:0] lfsr_ff;
    logic [31:0] prot_ff;
    logic [31:0] prot_saved_ff;
    logic prot_locked_ff;
    logic [1:0] key_stage_ff;
    logic pass_ff, fail_ff, irq_ff;
    logic [FCC_TMR_W-1:0] timer_ff;
    logic [13:0] cnt_ff, end_ff;
    logic sign_vld_ff;
    logic abort_ff;
    logic [31:0] rdata_ff;
    logic [15:0] mem_rdata;
    fcc_mem_req_s mem_req;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire idle = (state_ff == FCC_IDLE);
    wire wr_mode = i_bus.wr && (i_bus.addr == FCC_ADDR_MODE);
    wire wr_cmd = i_bus.wr && (i_bus.addr == FCC_ADDR_CMD);
    wire wr_data = i_bus.wr && (i_bus.addr == FCC_ADDR_DATA);
    wire wr_waddr = i_bus.wr && (i_bus.addr == FCC_ADDR_WADDR);
    wire wr_prot = i_bus.wr && (i_bus.addr == FCC_ADDR_PROT);
    wire rd_status = i_bus.rd && (i_bus.addr == FCC_ADDR_STATUS);
    wire [7:0] code = i_bus.wdata[7:0];

    // ------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------
    // Commands written while busy are dropped, so a running sequence never sees its
    // address or mode change underneath it through a second start.
    wire issue = wr_cmd && idle;
    wire is_array = (code >= FCC_OP_READ) && (code <= FCC_OP_PAGE_ERASE);
    wire is_known = (code <= FCC_OP_MASS_ERASE) || (code == FCC_OP_SIGN)
        || (code == FCC_OP_PROTECT) || (code == FCC_OP_PING);
    wire is_prog = (code == FCC_OP_WRITE) || (code == FCC_OP_ERASE_WRITE)
        || (code == FCC_OP_PAGE_ERASE) || (code == FCC_OP_MASS_ERASE);
    wire range_bad = is_array && (waddr_ff > FCC_USER_ADDR_MAX); // [R20]
    wire prot_bad = is_prog && !mode_ff[FCC_MODE_WREN]; // [R06]
    wire key_bad = (code == FCC_OP_MASS_ERASE) && (key_stage_ff != 2'd3); // [R18]
    wire once_bad = (code == FCC_OP_PROTECT) && prot_locked_ff; // [R16]
    // Reserved codes and the null code never start anything.
    wire runs = issue && is_known && (code != FCC_OP_NULL); // [R21]
    wire reject = runs && (range_bad || prot_bad || key_bad || once_bad);
    wire go = runs && !reject;

    // ------------------------------------------------------------------
    // Completion events
    // ------------------------------------------------------------------
    wire mismatch = (op_ff == FCC_OP_VERIFY) && (mem_rdata != data_ff);
    wire fin_run = (state_ff == FCC_CAP) || ((state_ff == FCC_WAIT) && (timer_ff == '0));
    wire done = fin_run || reject;
    wire done_fail = reject || ((state_ff == FCC_CAP) && mismatch); // [R12]
    wire done_pass = fin_run && !done_fail;
    wire [7:0] done_op = reject ? code : op_ff;

    // ------------------------------------------------------------------
    // Start points and timing per command
    // ------------------------------------------------------------------
    wire [13:0] word = waddr_ff[14:1];
    wire whole = (code == FCC_OP_MASS_ERASE) || (code == FCC_OP_SIGN);
    wire [13:0] start_word = whole ? 14'h0000 : {word[13:8], 8'h00}; // [R13]
    wire [13:0] last_word = whole ? FCC_USER_LAST : {word[13:8], FCC_PAGE_LAST}; // [R14]
    wire [FCC_TMR_W-1:0] op_cycles =
        (code == FCC_OP_WRITE) ? FCC_WRITE_CYCLES : // [R10]
        (code == FCC_OP_ERASE_WRITE) ? FCC_TMR_W'(P_ERASE_WRITE_CYCLES) : // [R11]
        (code == FCC_OP_PAGE_ERASE) ? FCC_TMR_W'(P_PAGE_ERASE_CYCLES) :
        (code == FCC_OP_MASS_ERASE) ? FCC_TMR_W'(P_MASS_ERASE_CYCLES) :
        (code == FCC_OP_SIGN) ? FCC_TMR_W'(P_SIGN_CYCLES - 1) : '0; // [R15]

    // Sequencer next state.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FCC_IDLE: begin
                if (go) begin
                    if ((code == FCC_OP_READ) || (code == FCC_OP_VERIFY)) begin
                        nxt_state = FCC_READ;
                    end else if (code == FCC_OP_WRITE) begin
                        nxt_state = FCC_PROG;
                    end else if ((code == FCC_OP_ERASE_WRITE) || (code == FCC_OP_PAGE_ERASE)
                        || (code == FCC_OP_MASS_ERASE)) begin
                        nxt_state = FCC_ERASE;
                    end else if (code == FCC_OP_SIGN) begin
                        nxt_state = FCC_SIGN;
                    end else begin
                        nxt_state = FCC_WAIT; // [R17]
                    end
                end
            end
            FCC_READ: nxt_state = FCC_CAP;
            FCC_CAP: nxt_state = FCC_IDLE;
            FCC_ERASE: begin
                if (cnt_ff == end_ff) begin
                    nxt_state = (op_ff == FCC_OP_ERASE_WRITE) ? FCC_PROG : FCC_WAIT; // [R11]
                end
            end
            FCC_PROG: nxt_state = FCC_WAIT;
            FCC_SIGN: begin
                if (cnt_ff == end_ff) begin
                    nxt_state = FCC_WAIT;
                end
            end
            FCC_WAIT: begin
                if (timer_ff == '0) begin
                    nxt_state = FCC_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Array port
    // ------------------------------------------------------------------
    // Loops walk the counter; single accesses use the address register.
    wire looping = (state_ff == FCC_ERASE) || (state_ff == FCC_SIGN);
    assign mem_req.addr = looping ? cnt_ff : word;
    assign mem_req.we = (state_ff == FCC_ERASE) || (state_ff == FCC_PROG); // [R10]
    assign mem_req.wdata = (state_ff == FCC_ERASE) ? FCC_ERASED : data_ff; // [R13]

    fcc_array u_array (
        .i_mclk(i_mclk),
        .i_req(mem_req),
        .o_rdata(mem_rdata)
    );

    // Sequencer, operation latch, timer and word counter.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= FCC_IDLE;
            op_ff <= FCC_OP_NULL;
            timer_ff <= '0;
            cnt_ff <= '0;
            end_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (go) begin
                op_ff <= code;
                timer_ff <= op_cycles;
                cnt_ff <= start_word;
                end_ff <= last_word;
            end else begin
                if (timer_ff != '0) begin
                    timer_ff <= timer_ff - 1'b1;
                end
                if (looping) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Signature
    // ------------------------------------------------------------------
    // Read data trail the address by a cycle, so the fold uses a delayed valid.
    wire lfsr_fb = ^(lfsr_ff & FCC_SIGN_TAPS);
    wire [23:0] nxt_lfsr = {lfsr_ff[22:0], lfsr_fb} ^ {8'h00, mem_rdata};
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sign_vld_ff <= 1'b0;
            lfsr_ff <= FCC_SIGN_RESET;
            sign_ff <= FCC_SIGN_RESET;
        end else begin
            sign_vld_ff <= (state_ff == FCC_SIGN);
            if (go) begin
                lfsr_ff <= FCC_SIGN_RESET;
            end else if (sign_vld_ff) begin
                lfsr_ff <= nxt_lfsr; // [R15]
            end
            if (fin_run && (op_ff == FCC_OP_SIGN)) begin
                sign_ff <= lfsr_ff; // [R15]
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode, data and address registers
    // ------------------------------------------------------------------
    // Reserved mode bits are stored as written; keeping them correct is up to software.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_ff <= FCC_MODE_RESET;
            data_ff <= FCC_DATA_RESET;
            waddr_ff <= FCC_WADDR_RESET;
        end else begin
            if (wr_mode) begin
                mode_ff <= i_bus.wdata[15:0]; // [R07]
            end
            if ((state_ff == FCC_CAP) && (op_ff == FCC_OP_READ)) begin
                data_ff <= mem_rdata; // [R09]
            end else if (wr_data) begin
                data_ff <= i_bus.wdata[15:0];
            end
            if (wr_waddr) begin
                waddr_ff <= i_bus.wdata[15:0];
            end
        end
    end

    // Mass erase key tracker: any out-of-order step restarts the sequence.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            key_stage_ff <= 2'd0;
        end else if (wr_data) begin
            key_stage_ff <= (i_bus.wdata[15:0] == FCC_KEY_DATA) ? 2'd1 : 2'd0; // [R18]
        end else if (wr_waddr) begin
            key_stage_ff <= ((key_stage_ff == 2'd1) && (i_bus.wdata[15:0] == FCC_KEY_ADDR))
                ? 2'd2 : 2'd0; // [R18]
        end else if (wr_mode) begin
            key_stage_ff <= ((key_stage_ff == 2'd2) && i_bus.wdata[FCC_MODE_WREN])
                ? 2'd3 : 2'd0; // [R18]
        end else if (wr_cmd) begin
            key_stage_ff <= 2'd0;
        end
    end

    // ------------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------------
    wire done_low = done && (done_op <= FCC_OP_MASS_ERASE);
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_ff <= FCC_CMD_RESET; // [R08]
        end else if (done_low || (issue && (code == FCC_OP_NULL))) begin
            cmd_ff <= FCC_CMD_DONE; // [R19]
        end else if (issue) begin
            cmd_ff <= code; // [R08]
        end
    end

    // ------------------------------------------------------------------
    // Protection
    // ------------------------------------------------------------------
    wire mass_done = fin_run && (op_ff == FCC_OP_MASS_ERASE);
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            prot_ff <= FCC_PROT_RESET;
            prot_saved_ff <= FCC_PROT_RESET;
            prot_locked_ff <= 1'b0;
        end else begin
            if (mass_done) begin
                prot_locked_ff <= 1'b0; // [R16]
                prot_saved_ff <= FCC_PROT_RESET;
            end else if (go && (code == FCC_OP_PROTECT)) begin
                prot_locked_ff <= 1'b1; // [R16]
                prot_saved_ff <= prot_ff;
            end else if (wr_prot && prot_locked_ff && (i_bus.wdata == FCC_PROT_KEY)) begin
                prot_locked_ff <= 1'b0; // [R16]
                prot_saved_ff <= FCC_PROT_RESET;
            end
            if (wr_prot && !(prot_locked_ff && (i_bus.wdata == FCC_PROT_KEY))) begin
                prot_ff <= i_bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // A completion in the same cycle as a status read wins, so no result is lost.
    wire nxt_pass = (pass_ff && !rd_status) || done_pass; // [R04]
    wire nxt_fail = (fail_ff && !rd_status) || (done && done_fail); // [R03]
    wire nxt_irq = (irq_ff && !rd_status) || (done && mode_ff[FCC_MODE_IRQEN]); // [R01] [R05]
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pass_ff <= 1'b0;
            fail_ff <= 1'b0;
            irq_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            pass_ff <= nxt_pass;
            fail_ff <= nxt_fail;
            irq_ff <= nxt_irq;
            abort_ff <= runs && range_bad; // [R20]
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [15:0] status_word = FCC_STATUS_RESET
        | (16'(irq_ff) << FCC_ST_IRQ)
        | (16'(!idle) << FCC_ST_BUSY) // [R02]
        | (16'(fail_ff) << FCC_ST_FAIL)
        | (16'(pass_ff) << FCC_ST_PASS);
    wire [31:0] rd_mux =
        (i_bus.addr == FCC_ADDR_STATUS) ? {16'h0000, status_word} :
        (i_bus.addr == FCC_ADDR_MODE) ? {16'h0000, mode_ff} :
        (i_bus.addr == FCC_ADDR_CMD) ? {24'h000000, cmd_ff} :
        (i_bus.addr == FCC_ADDR_DATA) ? {16'h0000, data_ff} :
        (i_bus.addr == FCC_ADDR_WADDR) ? {16'h0000, waddr_ff} :
        (i_bus.addr == FCC_ADDR_SIGN) ? {8'h00, sign_ff} :
        (i_bus.addr == FCC_ADDR_PROT) ? prot_ff : 32'h00000000;

    // Read data are held until the next read.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_ff <= 32'h00000000;
        end else if (i_bus.rd) begin
            rdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_bus_rdata = rdata_ff;
    assign o_data_abort = abort_ff;
    assign o_flash_irq = irq_ff; // [R05]
    assign o_busy = !idle; // [R02]
    assign o_protection = prot_saved_ff;
    assign o_protection_locked = prot_locked_ff;

endmodule

// >>> test/fcc_checker.sv
// Port checks of the flash command controller.
`timescale 1ns/10ps
module fcc_checker (
    // Clock, reset and bus.
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire fcc_pkg::fcc_bus_req_s i_bus,
    // Outputs watched.
    input wire logic [31:0] o_bus_rdata,
    input wire logic o_data_abort,
    input wire logic o_flash_irq,
    input wire logic o_busy,
    input wire logic [31:0] o_protection,
    input wire logic o_protection_locked
);
    import fcc_pkg::*;
    // ----
    // Checks
    // ----
    // Decoded strobes; a command written while busy is ignored, so the ping, reserved-code and signature checks need idle.
    wire cmd_wr = i_bus.wr && i_bus.addr == FCC_ADDR_CMD;
    wire st_rd = i_bus.rd && i_bus.addr == FCC_ADDR_STATUS;
    wire [7:0] code = i_bus.wdata[7:0];
    wire rsvd = code inside {8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    chk_irq_until_read: assert property ($fell(o_flash_irq) |-> $past(st_rd))
        else $error("irq dropped without status read");
    chk_abort_cause: assert property (o_data_abort |-> $past(cmd_wr) && $past(code) inside {[1:5]})
        else $error("abort without command");
    chk_ping_short: assert property (cmd_wr && code == FCC_OP_PING && !o_busy |=> o_busy ##1 !o_busy)
        else $error("ping length wrong");
    chk_busy_cause: assert property ($rose(o_busy) |-> $past(cmd_wr))
        else $error("busy without command");
    chk_irq_cause: assert property ($rose(o_flash_irq) |-> $fell(o_busy) || $past(cmd_wr))
        else $error("irq without completion");
    chk_status_copy: assert property (st_rd |=> o_bus_rdata[3:2] == {$past(o_flash_irq), $past(o_busy)})
        else $error("status bits differ");
    chk_rsvd_quiet: assert property (cmd_wr && rsvd && !o_busy |=> !o_busy && $stable(o_flash_irq))
        else $error("reserved code acted");
    chk_sign_long: assert property (cmd_wr && code == FCC_OP_SIGN && !o_busy |=> o_busy [*8])
        else $error("signature ended early");
    cover property (cmd_wr && code == FCC_OP_MASS_ERASE);
    cover property ($rose(o_data_abort));
    cover property ($rose(o_protection_locked));
endmodule

// >>> test/tb_flash_command_controller.sv
// Self-checking bench of the flash command controller.
`timescale 1ns/10ps
module tb_flash_command_controller;
    import fcc_pkg::*;
    logic i_mclk, i_rstn, o_data_abort, o_flash_irq, o_busy, o_protection_locked;
    fcc_bus_req_s i_bus;
    logic [31:0] o_bus_rdata, o_protection, rd_val;
    logic [15:0] dat, adr;
    logic [7:0] rsv[6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
    int failures, samples_checked, cycles, took, seed, mem[int];
    // Long erases are shortened so the run stays brief.
    fcc_ctrl #(.P_ERASE_WRITE_CYCLES(300), .P_PAGE_ERASE_CYCLES(300),
        .P_MASS_ERASE_CYCLES(16000), .P_SIGN_CYCLES(15400)) uut (.i_mclk, .i_rstn, .i_bus,
        .o_bus_rdata, .o_data_abort, .o_flash_irq, .o_busy, .o_protection, .o_protection_locked);
    // ----
    // Tasks
    // ----
    // Clock and a cycle ceiling against hangs.
    initial begin
        i_mclk = 0;
        forever #25 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            end_of_test;
        end
    end
    task automatic end_of_test;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-cycle strobe; read data is registered, so it is taken one cycle later.
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(negedge i_mclk);
        i_bus = '{w, !w, a, d};
        @(negedge i_mclk);
        i_bus = '0;
        rd_val = o_bus_rdata;
    endtask
    function automatic logic [31:0] st(input bit ok, input bit ie);
        return 32'(32'h20 + (ok ? 1 : 2) + (ie ? 8 : 0));
    endfunction
    // Issue a command, wait while busy, then compare the status word.
    task automatic cmd(input logic [7:0] c, input logic [31:0] exp);
        acc(1, FCC_ADDR_CMD, {24'h0, c});
        for (took = 0; o_busy !== 1'b0; took++) @(negedge i_mclk);
        acc(0, FCC_ADDR_STATUS, 0);
        cmp("status", exp, rd_val);
    endtask
    task automatic rdw;
        cmd(FCC_OP_READ, st(1, 1));
        acc(0, FCC_ADDR_DATA, 0);
        cmp("data", 32'(mem[adr[14:1]]), rd_val);
    endtask
    initial begin
        i_rstn = 0;
        i_bus = '0;
        seed = 14886;
        repeat (8) @(negedge i_mclk);
        i_rstn = 1;
        acc(0, FCC_ADDR_STATUS, 0); cmp("status", 32'h20, rd_val);
        acc(0, FCC_ADDR_CMD, 0); cmp("command", 32'h07, rd_val);
        acc(0, FCC_ADDR_MODE, 0); cmp("mode", 32'h0, rd_val);
        acc(1, FCC_ADDR_MODE, 32'h118);
        for (int i = 0; i < 3; i++) begin
            adr = 16'($random(seed)) & 16'h3ffe;
            dat = 16'($random(seed));
            acc(1, FCC_ADDR_DATA, {16'h0, dat});
            acc(1, FCC_ADDR_WADDR, {16'h0, adr});
            cmd(FCC_OP_WRITE, st(1, 1));
            cmp("write time", 1, 32'(took > FCC_WRITE_CYCLES - 10 && took < FCC_WRITE_CYCLES + 10));
            mem[adr[14:1]] = dat;
            acc(1, FCC_ADDR_DATA, {16'h0, ~dat});
            cmd(FCC_OP_VERIFY, st(0, 1));
            rdw;
            cmd(FCC_OP_VERIFY, st(1, 1));
        end
        acc(0, FCC_ADDR_STATUS, 0); cmp("status", 32'h20, rd_val);
        acc(0, FCC_ADDR_CMD, 0); cmp("command", 32'h07, rd_val);
        acc(1, FCC_ADDR_MODE, 32'h110);
        acc(1, FCC_ADDR_DATA, 0);
        cmd(FCC_OP_WRITE, st(0, 1));
        rdw;
        acc(1, FCC_ADDR_WADDR, 32'h7800);
        cmd(FCC_OP_READ, st(0, 1));
        acc(1, FCC_ADDR_WADDR, {16'h0, adr});
        acc(1, FCC_ADDR_MODE, 32'h100);
        cmd(FCC_OP_PING, st(1, 0));
        for (int i = 0; i < 6; i++) cmd(rsv[i], 32'h20);
        cmd(FCC_OP_NULL, 32'h20);
        acc(0, FCC_ADDR_CMD, 0); cmp("command", 32'h07, rd_val);
        acc(1, FCC_ADDR_MODE, 32'h118);
        acc(1, FCC_ADDR_DATA, {16'h0, ~dat});
        cmd(FCC_OP_ERASE_WRITE, st(1, 1));
        foreach (mem[k]) if (k / 256 == adr[14:9]) mem[k] = 'hffff;
        mem[adr[14:1]] = {~dat};
        rdw;
        cmd(FCC_OP_PAGE_ERASE, st(1, 1));
        mem[adr[14:1]] = 'hffff;
        rdw;
        cmd(FCC_OP_MASS_ERASE, st(0, 1));
        acc(1, FCC_ADDR_DATA, {16'h0, FCC_KEY_DATA});
        acc(1, FCC_ADDR_WADDR, {16'h0, FCC_KEY_ADDR});
        acc(1, FCC_ADDR_MODE, 32'h118);
        cmd(FCC_OP_MASS_ERASE, st(1, 1));
        foreach (mem[k]) mem[k] = 'hffff;
        acc(1, FCC_ADDR_WADDR, {16'h0, adr});
        rdw;
        cmd(FCC_OP_SIGN, st(1, 1));
        acc(1, FCC_ADDR_PROT, 32'h3c);
        cmd(FCC_OP_PROTECT, st(1, 1));
        cmp("locked", 1, {31'h0, o_protection_locked});
        cmp("saved", 32'h3c, o_protection);
        cmd(FCC_OP_PROTECT, st(0, 1));
        end_of_test;
    end
endmodule
bind fcc_ctrl fcc_checker chk (.i_mclk, .i_rstn, .i_bus, .o_bus_rdata, .o_data_abort,
    .o_flash_irq, .o_busy, .o_protection, .o_protection_locked);
